// file: pis_params.svh
// constants for the power-up init sequencer host controller
`ifndef PIS_PARAMS_SVH
`define PIS_PARAMS_SVH
`define PIS_CLK_PERIOD_NS 10
`define PIS_I2C_READY_MS 2
`define PIS_HARD_RESET_MS 2
`define PIS_CLK_STABLE_US 1
`define PIS_I2C_READY_CYC (`PIS_I2C_READY_MS * 1000000 / `PIS_CLK_PERIOD_NS)
`define PIS_HARD_RESET_CYC (`PIS_HARD_RESET_MS * 1000000 / `PIS_CLK_PERIOD_NS)
`define PIS_CLK_STABLE_CYC (`PIS_CLK_STABLE_US * 1000 / `PIS_CLK_PERIOD_NS)
`define PIS_REG_EVT_DUR 8'h16
`define PIS_REG_IND_TGT 8'h40
`define PIS_REG_IND_OFS 8'h41
`define PIS_REG_IND_DAT 8'h42
`define PIS_REG_PLL_FRST 8'h5b
`define PIS_PLL_FRST_BIT 5
`define PIS_EVT_DUR_VAL 8'h02
`define PIS_TGT_HDMI_PLL 8'h10
`define PIS_TGT_LINK_PLL 8'h14
`define PIS_IND_OFS_VAL 8'h49
`define PIS_IND_RST_ON 8'h10
`define PIS_IND_RST_OFF 8'h00
`define PIS_A_CTRL 12'h000
`define PIS_A_STAT 12'h004
`define PIS_A_PLLVAL 12'h008
`define PIS_A_UCFG 12'h00c
`define PIS_CTRL_GO 0
`define PIS_CTRL_HRST 1
`define PIS_CTRL_CLKOK 2
`define PIS_STEP_N 11
`endif

// file: pis_pkg.sv
// types for the power-up init sequencer host controller
package pis_pkg;
  typedef enum logic [8:0] {
    S_OFF = 9'h001,
    S_RESET = 9'h002,
    S_READY = 9'h004,
    S_PRE = 9'h008,
    S_SEQA = 9'h010,
    S_WCLK = 9'h020,
    S_SEQB = 9'h040,
    S_DONE = 9'h080,
    S_RDPLL = 9'h100
  } pis_state_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } pis_wr_t;
  typedef struct packed {
    logic busy;
    logic done;
  } pis_wr_stat_t;
endpackage

// file: pis_axil.sv
// axi4-lite slave holding the controller's command and status words
`timescale 1ns/100ps
`include "pis_params.svh"
module pis_axil (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [7:0] ctrl,
  output logic ctrl_wr,
  output logic [7:0] ucfg_addr,
  output logic [7:0] ucfg_data,
  output logic ucfg_en,
  input wire logic [31:0] stat,
  input wire logic [7:0] pllval
);
  typedef struct packed {
    logic aw;
    logic [11:0] awaddr;
    logic w;
    logic [31:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] ctrl;
    logic ctrl_wr;
    logic [16:0] ucfg;
  } pis_axs_t;
  pis_axs_t q, d;
  logic do_wr;
  assign s_axi_awready = !q.aw && !q.bvalid;
  assign s_axi_wready = !q.w && !q.bvalid;
  assign s_axi_arready = !q.rvalid;
  assign do_wr = q.aw && q.w && !q.bvalid;
  always_comb begin
    d = q;
    d.ctrl_wr = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w = 1'b1;
      d.wdata = s_axi_wdata;
    end
    if (do_wr) begin
      d.aw = 1'b0;
      d.w = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = 2'h0;
      case (q.awaddr)
        `PIS_A_CTRL: begin
          d.ctrl = q.wdata[7:0];
          d.ctrl_wr = 1'b1;
        end
        `PIS_A_UCFG: d.ucfg = q.wdata[16:0];
        `PIS_A_STAT, `PIS_A_PLLVAL: d.bresp = 2'h0;
        default: d.bresp = 2'h2;
      endcase
    end
    if (q.bvalid && s_axi_bready) d.bvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      d.rvalid = 1'b1;
      d.rresp = 2'h0;
      case (s_axi_araddr)
        `PIS_A_CTRL: d.rdata = {24'h000000, q.ctrl};
        `PIS_A_STAT: d.rdata = stat;
        `PIS_A_PLLVAL: d.rdata = {24'h000000, pllval};
        `PIS_A_UCFG: d.rdata = {15'h0000, q.ucfg};
        default: begin
          d.rdata = 32'h00000000;
          d.rresp = 2'h2;
        end
      endcase
    end
    if (q.rvalid && s_axi_rready) d.rvalid = 1'b0;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) q <= '0;
    else q <= d;
  end
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign ctrl = q.ctrl;
  assign ctrl_wr = q.ctrl_wr;
  assign ucfg_addr = q.ucfg[15:8];
  assign ucfg_data = q.ucfg[7:0];
  assign ucfg_en = q.ucfg[16];
endmodule

// file: pis_host.sv
// host controller sequencing power enable, init sequence a and init sequence b
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "pis_params.svh"
module pis_host #(
  parameter int unsigned I2C_READY_CYC = `PIS_I2C_READY_CYC,
  parameter int unsigned HARD_RESET_CYC = `PIS_HARD_RESET_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic supplies_ok,
  output logic power_enable_pin,
  output logic hdmi_input_en,
  output logic gpio_hold,
  output logic reg_req_valid,
  output logic reg_req_read,
  output pis_pkg::pis_wr_t reg_req,
  input wire logic reg_req_ready,
  input wire logic reg_rsp_valid,
  input wire logic [7:0] reg_rsp_data,
  input wire logic reg_rsp_err
);
  typedef struct packed {
    pis_pkg::pis_state_t st;
    logic [31:0] cnt;
    logic [3:0] step;
    logic req;
    logic rd;
    pis_pkg::pis_wr_t wr;
    logic [7:0] pllval;
    logic pen;
    logic hdmi;
    logic err;
    logic done;
    logic go;
    logic clkok;
  } pis_hs_t;
  pis_hs_t q, d;
  logic [7:0] ctrl, ucfg_addr, ucfg_data;
  logic ctrl_wr, ucfg_en;
  logic [31:0] stat;
  pis_pkg::pis_wr_t seqb [0:7];
  localparam int unsigned STABLE_CYC = `PIS_CLK_STABLE_CYC;
  // sequence b table, indexed by step
  // both pll resets share the indirect offset; only the target byte differs
  assign seqb[0] = '{`PIS_REG_IND_TGT, `PIS_TGT_HDMI_PLL};
  assign seqb[1] = '{`PIS_REG_IND_OFS, `PIS_IND_OFS_VAL};
  assign seqb[2] = '{`PIS_REG_IND_DAT, `PIS_IND_RST_ON};
  assign seqb[3] = '{`PIS_REG_IND_DAT, `PIS_IND_RST_OFF};
  assign seqb[4] = '{`PIS_REG_IND_TGT, `PIS_TGT_LINK_PLL};
  assign seqb[5] = '{`PIS_REG_IND_OFS, `PIS_IND_OFS_VAL};
  assign seqb[6] = '{`PIS_REG_IND_DAT, `PIS_IND_RST_ON};
  assign seqb[7] = '{`PIS_REG_IND_DAT, `PIS_IND_RST_OFF};
  pis_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .ctrl(ctrl),
    .ctrl_wr(ctrl_wr),
    .ucfg_addr(ucfg_addr),
    .ucfg_data(ucfg_data),
    .ucfg_en(ucfg_en),
    .stat(stat),
    .pllval(q.pllval)
  );
  assign stat = {16'h0000, 3'h0, q.st[8:0], q.err, q.done, q.hdmi, q.pen};
  always_comb begin
    d = q;
    if (ctrl_wr) begin
      d.go = ctrl[`PIS_CTRL_GO];
      d.clkok = ctrl[`PIS_CTRL_CLKOK];
    end else begin
      d.clkok = ctrl[`PIS_CTRL_CLKOK];
    end
    if (q.req && reg_req_ready) d.req = 1'b0;
    if (ctrl_wr && ctrl[`PIS_CTRL_HRST] && q.pen) begin
      // restart the sequence; err and pllval keep their values, go takes bit 0 of the written word
      // a request in flight is dropped; the device is reset under it anyway
      d.st = pis_pkg::S_RESET;
      d.pen = 1'b0;
      d.hdmi = 1'b0;
      d.done = 1'b0;
      d.req = 1'b0;
      d.cnt = '0;
    end else begin
      case (q.st)
        pis_pkg::S_OFF: begin
          if (q.go && supplies_ok) begin
            d.pen = 1'b1;
            d.st = pis_pkg::S_READY;
            d.cnt = '0;
          end
        end
        pis_pkg::S_RESET: begin
          d.cnt = q.cnt + 32'd1;
          if (q.cnt >= HARD_RESET_CYC - 1) begin
            d.st = pis_pkg::S_OFF;
            d.cnt = '0;
          end
        end
        pis_pkg::S_READY: begin
          d.cnt = q.cnt + 32'd1;
          if (q.cnt >= I2C_READY_CYC - 1) begin
            d.st = pis_pkg::S_RDPLL;
            d.rd = 1'b1;
            d.req = 1'b1;
            d.wr = '{`PIS_REG_PLL_FRST, 8'h00};
          end
        end
        pis_pkg::S_RDPLL: begin
          if (reg_rsp_valid) begin
            d.pllval = reg_rsp_data;
            d.err = q.err | reg_rsp_err;
            d.rd = 1'b0;
            d.req = 1'b1;
            d.wr = '{`PIS_REG_PLL_FRST, reg_rsp_data & ~(8'h01 << `PIS_PLL_FRST_BIT)};
            d.st = pis_pkg::S_SEQA;
            d.step = 4'd0;
          end
        end
        pis_pkg::S_SEQA: begin
          if (reg_rsp_valid) begin
            d.err = q.err | reg_rsp_err;
            d.step = q.step + 4'd1;
            if (q.step == 4'd0) begin
              d.req = 1'b1;
              d.wr = '{`PIS_REG_EVT_DUR, `PIS_EVT_DUR_VAL};
            end else if (q.step == 4'd1 && ucfg_en) begin
              d.req = 1'b1;
              d.wr = '{ucfg_addr, ucfg_data};
            end else begin
              d.hdmi = 1'b1;
              d.st = pis_pkg::S_WCLK;
              d.cnt = '0;
            end
          end
        end
        pis_pkg::S_WCLK: begin
          if (!q.clkok) d.cnt = '0;
          else d.cnt = q.cnt + 32'd1;
          if (q.clkok && q.cnt >= STABLE_CYC - 1) begin
            d.st = pis_pkg::S_SEQB;
            d.step = 4'd0;
            d.req = 1'b1;
            d.wr = seqb[0];
          end
        end
        pis_pkg::S_SEQB: begin
          if (reg_rsp_valid) begin
            d.err = q.err | reg_rsp_err;
            d.step = q.step + 4'd1;
            if (q.step < 4'd7) begin
              d.req = 1'b1;
              d.wr = seqb[3'(q.step + 4'd1)];
            end else if (q.step == 4'd7 && ucfg_en) begin
              d.req = 1'b1;
              d.wr = '{ucfg_addr, ucfg_data};
            end else begin
              d.done = 1'b1;
              d.st = pis_pkg::S_DONE;
            end
          end
        end
        // parked until a hard reset restarts the sequence
        pis_pkg::S_DONE: d.st = pis_pkg::S_DONE;
        default: d.st = pis_pkg::S_OFF;
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.st <= pis_pkg::S_OFF;
    end else begin
      q <= d;
    end
  end
  assign power_enable_pin = q.pen;
  assign hdmi_input_en = q.hdmi;
  assign gpio_hold = !q.pen;
  assign reg_req_valid = q.req;
  assign reg_req_read = q.rd;
  assign reg_req = q.wr;
  // i2c ready counter: no request, read or write, may start before it expires
  logic [31:0] since_pen;
  always_ff @(posedge aclk) begin
    if (!aresetn || !q.pen) since_pen <= '0;
    else if (since_pen != 32'hffffffff) since_pen <= since_pen + 32'd1;
  end

  // low time of the enable pin, saturating so a long off period never wraps
  logic [31:0] low_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn || q.pen) low_cnt <= '0;
    else if (low_cnt != 32'hffffffff) low_cnt <= low_cnt + 32'd1;
  end

  // the first rise after reset ends no hard reset pulse, so it is not timed
  logic pen_seen_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) pen_seen_q <= 1'b0;
    else if (q.pen) pen_seen_q <= 1'b1;
  end

  // cycles for which software has reported the hdmi clock stable
  logic [31:0] clk_run_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || !q.clkok) clk_run_q <= '0;
    else if (clk_run_q != 32'hffffffff) clk_run_q <= clk_run_q + 32'd1;
  end

  a_i2c_ready_wait: assert property (@(posedge aclk) disable iff (!aresetn)
    reg_req_valid |-> since_pen >= I2C_READY_CYC)
    else $error("i2c access before ready");
  a_pen_needs_supply: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(power_enable_pin) |-> $past(supplies_ok))
    else $error("enable before supply");
  a_hdmi_after_pen: assert property (@(posedge aclk) disable iff (!aresetn)
    hdmi_input_en |-> power_enable_pin)
    else $error("hdmi without enable");
  a_hdmi_drop_pen: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(hdmi_input_en) |-> !power_enable_pin)
    else $error("hdmi dropped while enabled");
  a_hard_reset_low: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(power_enable_pin) && pen_seen_q |-> low_cnt >= HARD_RESET_CYC)
    else $error("reset pulse short");
  a_pen_fall_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(power_enable_pin) |-> q.st == pis_pkg::S_RESET)
    else $error("enable fell outside hard reset");
  a_seqb_after_clk: assert property (@(posedge aclk) disable iff (!aresetn)
    q.st == pis_pkg::S_SEQB |-> q.clkok || $past(q.clkok))
    else $error("seq b early");
  a_no_req_wclk: assert property (@(posedge aclk) disable iff (!aresetn)
    q.st == pis_pkg::S_WCLK |-> !reg_req_valid)
    else $error("request while waiting for clock");
  a_seqb_margin: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(q.st == pis_pkg::S_SEQB) |-> clk_run_q >= STABLE_CYC)
    else $error("seq b inside stable margin");
  a_read_first: assert property (@(posedge aclk) disable iff (!aresetn)
    q.st == pis_pkg::S_RDPLL && reg_req_valid |-> reg_req_read && reg_req.addr == `PIS_REG_PLL_FRST)
    else $error("bad pll read");
  a_read_only_pll: assert property (@(posedge aclk) disable iff (!aresetn)
    reg_req_valid && reg_req_read |-> q.st == pis_pkg::S_RDPLL)
    else $error("stray read");
  a_seqa_first_write: assert property (@(posedge aclk) disable iff (!aresetn)
    q.st == pis_pkg::S_SEQA && q.step == 4'd0 && reg_req_valid |-> reg_req.addr == `PIS_REG_PLL_FRST && !reg_req.data[`PIS_PLL_FRST_BIT])
    else $error("bad pll write");
  a_seqa_dur_write: assert property (@(posedge aclk) disable iff (!aresetn)
    q.st == pis_pkg::S_SEQA && q.step == 4'd1 && reg_req_valid |-> reg_req.addr == `PIS_REG_EVT_DUR && reg_req.data == `PIS_EVT_DUR_VAL)
    else $error("bad dur write");
  a_seqb_order: assert property (@(posedge aclk) disable iff (!aresetn)
    q.st == pis_pkg::S_SEQB && q.step < 4'd8 && reg_req_valid |-> reg_req == seqb[q.step[2:0]])
    else $error("seq b order");
  a_seqb_hdmi_tgt: assert property (@(posedge aclk) disable iff (!aresetn)
    q.st == pis_pkg::S_SEQB && q.step == 4'd0 && reg_req_valid |-> reg_req.addr == `PIS_REG_IND_TGT && reg_req.data == `PIS_TGT_HDMI_PLL)
    else $error("bad hdmi pll target");
  a_seqb_release: assert property (@(posedge aclk) disable iff (!aresetn)
    q.st == pis_pkg::S_SEQB && (q.step == 4'd3 || q.step == 4'd7) && reg_req_valid |-> reg_req.addr == `PIS_REG_IND_DAT && reg_req.data == `PIS_IND_RST_OFF)
    else $error("pll reset not released");
  a_seqb_link_tgt: assert property (@(posedge aclk) disable iff (!aresetn)
    q.st == pis_pkg::S_SEQB && q.step == 4'd4 && reg_req_valid |-> reg_req.addr == `PIS_REG_IND_TGT && reg_req.data == `PIS_TGT_LINK_PLL)
    else $error("bad link pll target");
  a_done_after_hdmi: assert property (@(posedge aclk) disable iff (!aresetn)
    q.done |-> hdmi_input_en)
    else $error("done without hdmi input");
  a_gpio_held: assert property (@(posedge aclk) disable iff (!aresetn)
    !power_enable_pin |-> gpio_hold && !reg_req_valid)
    else $error("gpio released");

  c_power_up: cover property (@(posedge aclk) disable iff (!aresetn) $rose(power_enable_pin));
  c_seqa_done: cover property (@(posedge aclk) disable iff (!aresetn) $rose(hdmi_input_en));
  c_all_done: cover property (@(posedge aclk) disable iff (!aresetn) $rose(q.done));
  c_hard_reset: cover property (@(posedge aclk) disable iff (!aresetn)
    q.st == pis_pkg::S_RESET);
  c_user_write: cover property (@(posedge aclk) disable iff (!aresetn)
    q.st == pis_pkg::S_SEQB && q.step == 4'd8 && reg_req_valid);
endmodule

// file: pis_dev_model.sv
// device model answering the controller's register requests
`timescale 1ns/100ps
module pis_dev_model #(
  parameter int unsigned READY_CYC = 50,
  parameter logic [7:0] FRST_INIT = 8'hff
) (
  input wire logic aclk,
  input wire logic power_enable_pin,
  input wire logic reg_req_valid,
  input wire logic reg_req_read,
  input wire pis_pkg::pis_wr_t reg_req,
  output logic reg_req_ready,
  output logic reg_rsp_valid,
  output logic [7:0] reg_rsp_data,
  output logic reg_rsp_err
);
  logic [7:0] regs [256];
  logic [15:0] log_q [$];
  logic [7:0] rdat = 8'h00;
  logic [7:0] nack_addr = 8'h00;
  logic busy = 1'b0;
  logic err = 1'b0;
  logic nack_en = 1'b0;
  logic bad;
  int unsigned up_cnt = 0;
  int unsigned wait_cnt = 0;
  int unsigned lat = 0;
  int unsigned early_cnt = 0;
  initial reg_rsp_valid = 1'b0;
  initial regs[8'h5b] = FRST_INIT;
  assign reg_req_ready = !busy && power_enable_pin === 1'b1;
  // access before ready time is refused
  assign bad = (up_cnt < READY_CYC) || (nack_en && reg_req.addr == nack_addr);
  // released lines show the inverse of the last value
  assign reg_rsp_data = reg_rsp_valid ? rdat : ~rdat;
  assign reg_rsp_err = reg_rsp_valid ? err : ~err;
  always @(posedge aclk) begin
    reg_rsp_valid <= 1'b0;
    if (power_enable_pin !== 1'b1) begin
      up_cnt <= 0;
      busy <= 1'b0;
      regs[8'h5b] <= FRST_INIT;
    end else begin
      if (up_cnt < READY_CYC) up_cnt <= up_cnt + 1;
      if (reg_req_valid && !busy) begin
        busy <= 1'b1;
        wait_cnt <= lat;
        err <= bad;
        if (up_cnt < READY_CYC) early_cnt <= early_cnt + 1;
        if (reg_req_read) begin
          rdat <= regs[reg_req.addr];
        end else if (!bad) begin
          regs[reg_req.addr] <= reg_req.data;
          log_q.push_back(reg_req);
        end
      end else if (busy) begin
        if (wait_cnt == 0) begin
          busy <= 1'b0;
          reg_rsp_valid <= 1'b1;
        end else begin
          wait_cnt <= wait_cnt - 1;
        end
      end
    end
  end
endmodule

// file: test_powerup_init_sequencer.sv
// self-checking bench for the power-up init sequencer controller
`timescale 1ns/100ps
module test_powerup_init_sequencer;
  localparam int RDY = 50;
  localparam int HRST = 50;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic supplies_ok = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, power_enable_pin, hdmi, gpio_hold;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp;
  logic req_valid, req_read, req_ready, rsp_valid, rsp_err;
  logic [7:0] rsp_data;
  pis_pkg::pis_wr_t req;
  int fail_count = 0, checks = 0, lowc = 0, last_low = 0, viol = 0;
  logic [31:0] s;
  logic [1:0] r;
  // first entry is 0xff with bit 5 cleared
  logic [15:0] exp_t [12] = '{16'h5bdf, 16'h1602, 16'h335a, 16'h4010, 16'h4149, 16'h4210,
    16'h4200, 16'h4014, 16'h4149, 16'h4210, 16'h4200, 16'h335a};
  always #5 aclk = ~aclk;
  pis_host #(.I2C_READY_CYC(RDY), .HARD_RESET_CYC(HRST)) DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .supplies_ok(supplies_ok), .power_enable_pin(power_enable_pin), .hdmi_input_en(hdmi),
    .gpio_hold(gpio_hold), .reg_req_valid(req_valid), .reg_req_read(req_read),
    .reg_req(req), .reg_req_ready(req_ready), .reg_rsp_valid(rsp_valid),
    .reg_rsp_data(rsp_data), .reg_rsp_err(rsp_err));
  pis_dev_model #(.READY_CYC(RDY)) dev (
    .aclk(aclk), .power_enable_pin(power_enable_pin), .reg_req_valid(req_valid),
    .reg_req_read(req_read), .reg_req(req), .reg_req_ready(req_ready),
    .reg_rsp_valid(rsp_valid), .reg_rsp_data(rsp_data), .reg_rsp_err(rsp_err));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic axw(input logic [11:0] a, input logic [31:0] v);
    bit aw_ok, w_ok;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    aw_ok = 0;
    w_ok = 0;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) begin
        aw_ok = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [11:0] a, output logic [31:0] v, output logic [1:0] e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    v = rdata;
    e = rresp;
    rready <= 1'b0;
  endtask
  task automatic wait_hdmi;
    int n;
    for (n = 0; n < 3000 && hdmi !== 1'b1; n++) @(posedge aclk);
    check(hdmi, 1'b1);
  endtask
  task automatic wait_done;
    int n;
    s = 32'h0;
    for (n = 0; n < 2000 && s[2] !== 1'b1; n++) axr(12'h004, s, r);
  endtask
  task automatic chk_log(input bit skip);
    int i, j;
    j = 0;
    check(dev.log_q.size(), skip ? 11 : 12);
    for (i = 0; i < 12; i++) begin
      if (!(skip && i == 1)) begin
        check(dev.log_q[j], exp_t[i]);
        j++;
      end
    end
  endtask
  // low time of the enable pin, and order hazards seen at any cycle
  always @(negedge aclk) begin
    if (power_enable_pin === 1'b1) begin
      if (lowc != 0) last_low = lowc;
      lowc = 0;
    end else begin
      lowc++;
    end
    if (aresetn && ((hdmi && !power_enable_pin) || (!power_enable_pin && gpio_hold !== 1'b1)
        || (!supplies_ok && (power_enable_pin || req_valid)))) viol++;
  end
  initial begin
    repeat (40000) @(posedge aclk);
    fail_count++;
    conclude;
  end
  initial begin
    int n;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check({power_enable_pin, hdmi, gpio_hold}, 3'b001);
    axr(12'h004, s, r);
    check(s[3:0], 4'h0);
    axr(12'h010, s, r);
    check(r, 2'b10);
    check(s, 32'h0);
    axw(12'h00c, 32'h0001_335a);
    check(r, 2'b00);
    axr(12'h00c, s, r);
    check(s, 32'h0001_335a);
    axw(12'h010, 32'h0);
    check(r, 2'b10);
    axw(12'h000, 32'h1);
    repeat (20) @(posedge aclk);
    check(power_enable_pin, 1'b0);
    supplies_ok <= 1'b1;
    wait_hdmi;
    check(dev.log_q.size(), 3);
    $display("test power-up and sequence a ended");
    axw(12'h000, 32'h5);
    repeat (95) @(posedge aclk);
    check(dev.log_q.size(), 3);
    wait_done;
    chk_log(1'b0);
    check(s[12:0], {pis_pkg::S_DONE, 4'h7});
    axr(12'h008, s, r);
    check(s[7:0], 8'hff);
    check(dev.early_cnt, 0);
    $display("test sequence b ended");
    dev.lat = 4;
    dev.nack_addr = 8'h16;
    dev.nack_en = 1'b1;
    axw(12'h000, 32'h7);
    for (n = 0; n < 200 && power_enable_pin !== 1'b0; n++) @(posedge aclk);
    dev.log_q.delete();
    wait_hdmi;
    check(last_low >= HRST, 1'b1);
    check(dev.log_q.size(), 2);
    wait_done;
    chk_log(1'b1);
    check(s[3:2], 2'b11);
    check(dev.early_cnt, 0);
    check(viol, 0);
    $display("test hard reset ended");
    conclude;
  end
endmodule
